/* verilog/qsd_top.sv */
// drive status mode bits and quick stop option handling
// wishbone slave for the option code, status and interrupt registers
// assumes mode and axis inputs are synchronous to clk_i
//
// Contract
// RL1: profile position bit 10: target reached, or axis stopped under halt.
// RL2: profile position bit 12: set point still processing or acknowledged.
// RL3: profile position bit 13: following error occurred.
// RL4: homing bits 13,12,10 encode progress, completion and error cases.
// RL5: cyclic modes bit 10: target reached; always 0 in cyclic torque.
// RL6: cyclic modes bit 12: cyclic target value enabled.
// RL7: cyclic bit 13: following error; 0 in cyclic velocity and torque.
// RL8: profile velocity: bit 10 halt rule, bit 12 speed zero, bit 13 0.
// RL9: profile torque: bit 10 halt rule, bits 12 and 13 read 0.
// RL10: option code is signed 16-bit, accepts 0 to 4, defaults to 2.
// RL11: code 0 removes motor power at once, then switch-on-disabled.
// RL12: code 1 decelerates at normal rate, then switch-on-disabled.
// RL13: code 2 decelerates at quick stop rate, then switch-on-disabled.
// RL14: code 3 decelerates at torque limit, then switch-on-disabled.
// RL15: torque modes always treat quick stop as code 0.
// RL16: interpolated position: bit 10 halt rule, bit 12 running, bit 13 0.
// RL17: controller drives halt; status bits depend on it.
// RL18: code 2 uses the separate quick stop deceleration rate.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
module qsd_top (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [31:0]       adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // motion core side
    input  wire logic [7:0]        mode_i,
    input  wire qsd_pkg::qsd_axis_t axis_i,
    input  wire logic              quick_stop_i,
    output logic      [15:0]       status_bits_o,
    output qsd_pkg::qsd_stop_t     stop_o,
    // interrupt
    output logic                   irq_o
);
    typedef enum logic [1:0] {
        QS_IDLE,
        QS_DECEL,
        QS_OFF
    } qsd_qs_state_t;

    logic                  ack_q;
    logic [31:0]           dat_q;
    logic signed [15:0]    qs_option_q;
    logic [4:0]            irq_mask_q;
    logic [15:0]           status_q;
    logic [15:0]           status_d;
    qsd_qs_state_t         qs_state_q;
    qsd_pkg::qsd_stop_t    stop_q;
    logic                  acc;
    logic                  wr_acc;
    logic                  rd_acc;
    logic                  hit_status;
    logic                  hit_option;
    logic                  hit_irq_st;
    logic                  hit_irq_mask;
    logic signed [15:0]    opt_wr;
    logic                  opt_bad;
    logic                  torque_mode;
    logic [2:0]            eff_code;
    logic [4:0]            ev_lvl;
    logic [4:0]            ev_rise;
    logic [4:0]            ev_set;
    logic [4:0]            ev_clr;
    logic [4:0]            ev_flags;
    logic                  halt_tgt;

    // bus decode; byte address is four times the register index
    assign acc          = cyc_i & stb_i & ~ack_q;
    assign wr_acc       = acc & we_i;
    assign rd_acc       = acc & ~we_i;
    assign hit_status   = adr_i == {14'h0000, qsd_pkg::QSD_IDX_STATUS, 2'b00};
    assign hit_option   = adr_i == {14'h0000, qsd_pkg::QSD_IDX_QS_OPTION,
                                    2'b00};
    assign hit_irq_st   = adr_i == {14'h0000, qsd_pkg::QSD_IDX_IRQ_STATUS,
                                    2'b00};
    assign hit_irq_mask = adr_i == {14'h0000, qsd_pkg::QSD_IDX_IRQ_MASK,
                                    2'b00};

    // byte lanes merged into the current option value before checking
    assign opt_wr  = {sel_i[1] ? dat_i[15:8] : qs_option_q[15:8],
                      sel_i[0] ? dat_i[7:0]  : qs_option_q[7:0]};
    assign opt_bad = (opt_wr < 16'sh0000) ||
                     (opt_wr > qsd_pkg::QSD_QS_OPTION_MAX); // RL10

    // single-wait-state ack; every address answers, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc;
        end
    end

    // read data register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (rd_acc) begin
            if (hit_status) begin
                dat_q <= {16'h0000, status_q};
            end else if (hit_option) begin
                dat_q <= {{16{qs_option_q[15]}}, qs_option_q};
            end else if (hit_irq_st) begin
                dat_q <= {27'h0000000, ev_flags};
            end else if (hit_irq_mask) begin
                dat_q <= {27'h0000000, irq_mask_q};
            end else begin
                dat_q <= 32'h0000_0000;
            end
        end
    end

    // option code; out-of-range writes keep the old value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            qs_option_q <= qsd_pkg::QSD_QS_OPTION_RST; // RL10
        end else if (wr_acc && hit_option && !opt_bad) begin
            qs_option_q <= opt_wr; // RL10
        end
    end

    // interrupt mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_q <= qsd_pkg::QSD_IRQ_MASK_RST;
        end else if (wr_acc && hit_irq_mask && sel_i[0]) begin
            irq_mask_q <= dat_i[4:0];
        end
    end

    // halt-dependent target rule shared by several modes
    assign halt_tgt = axis_i.halt ? axis_i.axis_stopped      // RL17
                                  : axis_i.target_reached;

    // mode specific bits 10, 12 and 13
    always_comb begin
        status_d = 16'h0000;
        case (mode_i)
            qsd_pkg::QSD_MODE_PP: begin
                status_d[qsd_pkg::QSD_BIT_TGT]   = halt_tgt;  // RL1
                status_d[qsd_pkg::QSD_BIT_OMS12] =
                    axis_i.setpoint_busy;                      // RL2
                status_d[qsd_pkg::QSD_BIT_OMS13] =
                    axis_i.following_error;                    // RL3
            end
            qsd_pkg::QSD_MODE_HM: begin
                // error wins over attained, then progress
                if (axis_i.homing_error) begin
                    status_d[qsd_pkg::QSD_BIT_OMS13] = 1'b1;  // RL4
                    status_d[qsd_pkg::QSD_BIT_TGT]   =
                        axis_i.speed_zero;                     // RL4
                end else if (axis_i.homing_attained) begin
                    status_d[qsd_pkg::QSD_BIT_OMS12] = 1'b1;  // RL4
                    status_d[qsd_pkg::QSD_BIT_TGT]   =
                        axis_i.axis_stopped;                   // RL4
                end else begin
                    status_d[qsd_pkg::QSD_BIT_TGT]   =
                        ~axis_i.homing_active;                 // RL4
                end
            end
            qsd_pkg::QSD_MODE_CSP: begin
                status_d[qsd_pkg::QSD_BIT_TGT]   =
                    axis_i.target_reached;                     // RL5
                status_d[qsd_pkg::QSD_BIT_OMS12] =
                    axis_i.cyclic_target_enabled;              // RL6
                status_d[qsd_pkg::QSD_BIT_OMS13] =
                    axis_i.following_error;                    // RL7
            end
            qsd_pkg::QSD_MODE_CSV: begin
                status_d[qsd_pkg::QSD_BIT_TGT]   =
                    axis_i.target_reached;                     // RL5
                status_d[qsd_pkg::QSD_BIT_OMS12] =
                    axis_i.cyclic_target_enabled;              // RL6
            end
            qsd_pkg::QSD_MODE_CST: begin
                // target reached and following error stay 0 here
                status_d[qsd_pkg::QSD_BIT_OMS12] =
                    axis_i.cyclic_target_enabled;              // RL6
            end
            qsd_pkg::QSD_MODE_IP: begin
                status_d[qsd_pkg::QSD_BIT_TGT]   = halt_tgt;  // RL16
                status_d[qsd_pkg::QSD_BIT_OMS12] =
                    axis_i.interpolation_running_flag;         // RL16
            end
            qsd_pkg::QSD_MODE_PV: begin
                status_d[qsd_pkg::QSD_BIT_TGT]   = halt_tgt;  // RL8
                status_d[qsd_pkg::QSD_BIT_OMS12] =
                    axis_i.speed_zero;                         // RL8
            end
            qsd_pkg::QSD_MODE_PT: begin
                status_d[qsd_pkg::QSD_BIT_TGT]   = halt_tgt;  // RL9
            end
            default: begin
                status_d = 16'h0000;
            end
        endcase
    end

    // status bits registered so the output is glitch free
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= 16'h0000;
        end else begin
            status_q <= status_d;
        end
    end

    // torque modes cannot decelerate on a ramp, so power goes off
    assign torque_mode = (mode_i == qsd_pkg::QSD_MODE_PT) ||
                         (mode_i == qsd_pkg::QSD_MODE_CST);
    assign eff_code    = torque_mode ? 3'd0 : qs_option_q[2:0]; // RL15

    // quick stop sequencer; code is sampled once when the stop starts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            qs_state_q        <= QS_IDLE;
            stop_q.power_off  <= 1'b0;
            stop_q.decel_src  <= qsd_pkg::QSD_DEC_NONE;
            stop_q.enter_sod  <= 1'b0;
        end else begin
            stop_q.enter_sod <= 1'b0;
            case (qs_state_q)
                QS_IDLE: begin
                    if (quick_stop_i) begin
                        case (eff_code)
                            3'd0: begin
                                stop_q.power_off <= 1'b1;       // RL11
                                stop_q.enter_sod <= 1'b1;       // RL11
                                qs_state_q       <= QS_OFF;
                            end
                            3'd1: begin
                                stop_q.decel_src <=
                                    qsd_pkg::QSD_DEC_NORMAL;    // RL12
                                qs_state_q       <= QS_DECEL;
                            end
                            3'd3: begin
                                stop_q.decel_src <=
                                    qsd_pkg::QSD_DEC_TORQUE_LIMIT; // RL14
                                qs_state_q       <= QS_DECEL;
                            end
                            default: begin
                                // codes 2 and 4 use the quick stop rate
                                stop_q.decel_src <=
                                    qsd_pkg::QSD_DEC_QUICK;     // RL13 RL18
                                qs_state_q       <= QS_DECEL;
                            end
                        endcase
                    end
                end
                QS_DECEL: begin
                    if (axis_i.axis_stopped) begin
                        stop_q.decel_src <= qsd_pkg::QSD_DEC_NONE;
                        stop_q.power_off <= 1'b1;    // RL12 RL13 RL14
                        stop_q.enter_sod <= 1'b1;    // RL12 RL13 RL14
                        qs_state_q       <= QS_OFF;
                    end
                end
                QS_OFF: begin
                    // power stays off until the stop request is withdrawn
                    if (!quick_stop_i) begin
                        stop_q.power_off <= 1'b0;
                        qs_state_q       <= QS_IDLE;
                    end
                end
                default: begin
                    qs_state_q <= QS_IDLE;
                end
            endcase
        end
    end

    // interrupt events
    assign ev_lvl = {1'b0,
                     qs_state_q == QS_OFF,
                     axis_i.homing_error,
                     status_q[qsd_pkg::QSD_BIT_OMS13],
                     status_q[qsd_pkg::QSD_BIT_TGT]};

    qsd_rise_det #(
        .W (qsd_pkg::QSD_EV_W)
    ) u_rise (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .lvl_i  (ev_lvl),
        .rise_o (ev_rise)
    );

    // rejected option writes are a pulse, not an edge
    always_comb begin
        ev_set = ev_rise;
        ev_set[qsd_pkg::QSD_EV_BAD_WR] = wr_acc & hit_option & opt_bad;
    end

    // read of the interrupt status register clears it at the acking edge
    assign ev_clr = {qsd_pkg::QSD_EV_W{rd_acc & hit_irq_st}};

    qsd_sticky #(
        .W (qsd_pkg::QSD_EV_W)
    ) u_sticky (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (ev_set),
        .clr_i  (ev_clr),
        .flag_o (ev_flags)
    );

    // outputs
    assign ack_o            = ack_q;
    assign dat_o            = dat_q;
    assign status_bits_o    = status_q;
    assign stop_o.power_off = stop_q.power_off;
    assign stop_o.decel_src = stop_q.decel_src;
    assign stop_o.enter_sod = stop_q.enter_sod;
    assign irq_o            = |(ev_flags & irq_mask_q);
endmodule

/* verilog/qsd_pkg.sv */
// package for the drive status mode bits and quick stop block
// assumes a 32-bit classic wishbone master and a 250 MHz system clock
package qsd_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] QSD_IDX_STATUS     = 16'h6041;
    localparam logic [15:0] QSD_IDX_QS_OPTION  = 16'h605A;
    localparam logic [15:0] QSD_IDX_IRQ_STATUS = 16'h7000;
    localparam logic [15:0] QSD_IDX_IRQ_MASK   = 16'h7001;

    // field positions inside the status word
    localparam int QSD_BIT_TGT   = 10;
    localparam int QSD_BIT_OMS12 = 12;
    localparam int QSD_BIT_OMS13 = 13;

    // values after reset and the accepted option range
    localparam logic signed [15:0] QSD_QS_OPTION_RST = 16'sh0002;
    localparam logic signed [15:0] QSD_QS_OPTION_MAX = 16'sh0004;
    localparam logic [4:0]         QSD_IRQ_MASK_RST  = 5'h00;

    // interrupt event positions
    localparam int QSD_EV_TGT      = 0;
    localparam int QSD_EV_FOLLOW   = 1;
    localparam int QSD_EV_HOME_ERR = 2;
    localparam int QSD_EV_QS_DONE  = 3;
    localparam int QSD_EV_BAD_WR   = 4;
    localparam int QSD_EV_W        = 5;

    // operating mode codes as shown by the mode display
    localparam logic [7:0] QSD_MODE_PP  = 8'h01;
    localparam logic [7:0] QSD_MODE_PV  = 8'h03;
    localparam logic [7:0] QSD_MODE_PT  = 8'h04;
    localparam logic [7:0] QSD_MODE_HM  = 8'h06;
    localparam logic [7:0] QSD_MODE_IP  = 8'h07;
    localparam logic [7:0] QSD_MODE_CSP = 8'h08;
    localparam logic [7:0] QSD_MODE_CSV = 8'h09;
    localparam logic [7:0] QSD_MODE_CST = 8'h0A;

    // deceleration source handed to the motion core
    typedef enum logic [1:0] {
        QSD_DEC_NONE,
        QSD_DEC_NORMAL,
        QSD_DEC_QUICK,
        QSD_DEC_TORQUE_LIMIT
    } qsd_dec_t;

    // live axis state from the motion core
    typedef struct packed {
        logic halt;
        logic target_reached;
        logic axis_stopped;
        logic setpoint_busy;
        logic following_error;
        logic homing_active;
        logic homing_attained;
        logic homing_error;
        logic cyclic_target_enabled;
        logic speed_zero;
        logic interpolation_running_flag;
    } qsd_axis_t;

    // quick stop commands to the power stage and motion core
    typedef struct packed {
        logic     power_off;
        qsd_dec_t decel_src;
        logic     enter_sod;
    } qsd_stop_t;

endpackage

/* verilog/qsd_rise_det.sv */
// rising edge detector, one bit per lane
// assumes inputs already synchronous to clk_i
`timescale 1ns/1ps
module qsd_rise_det #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // level in, pulse out
    input  wire logic [W-1:0] lvl_i,
    output logic      [W-1:0] rise_o
);
    logic [W-1:0] prev_q;

    // previous level, cleared so a high level at release counts as an edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= '0;
        end else begin
            prev_q <= lvl_i;
        end
    end

    assign rise_o = lvl_i & ~prev_q;
endmodule

/* verilog/qsd_sticky.sv */
// sticky flag bank: set wins over clear
// assumes set and clear are one-cycle pulses on clk_i
`timescale 1ns/1ps
module qsd_sticky #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // set and clear strobes
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    output logic      [W-1:0] flag_o
);
    logic [W-1:0] flag_q;

    // an event in the clearing cycle must not be lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= '0;
        end else begin
            flag_q <= (flag_q & ~clr_i) | set_i;
        end
    end

    assign flag_o = flag_q;
endmodule

/* verif/qsd_chk.sv */
// checker for the status mode bits and quick stop outputs
// assumes it is bound to qsd_top and sees only its ports
`timescale 1ns/1ps
module qsd_chk (
    // clock and reset
    input wire logic               clk_i,
    input wire logic               rst_i,
    // wishbone slave
    input wire logic               cyc_i,
    input wire logic               stb_i,
    input wire logic               we_i,
    input wire logic [31:0]        adr_i,
    input wire logic [3:0]         sel_i,
    input wire logic [31:0]        dat_i,
    input wire logic [31:0]        dat_o,
    input wire logic               ack_o,
    // motion core side
    input wire logic [7:0]         mode_i,
    input wire qsd_pkg::qsd_axis_t axis_i,
    input wire logic               quick_stop_i,
    input wire logic [15:0]        status_bits_o,
    input wire qsd_pkg::qsd_stop_t stop_o,
    // interrupt
    input wire logic               irq_o
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // bus answer comes one cycle after the request and lasts one cycle
    bus_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack did not follow request");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    // halt decides between target reached and axis stopped
    halt_target_a: assert property (mode_i inside {8'h01, 8'h07, 8'h03,
        8'h04} |=> status_bits_o[10] == ($past(axis_i.halt) ?
        $past(axis_i.axis_stopped) : $past(axis_i.target_reached)))
        else $error("bit 10 halt rule broken");
    pp_upper_a: assert property (mode_i == 8'h01 |=> status_bits_o[13:12]
        == {$past(axis_i.following_error), $past(axis_i.setpoint_busy)})
        else $error("profile position bits 12 13 wrong");
    csp_bits_a: assert property (mode_i == 8'h08 |=> status_bits_o[13:10]
        == {$past(axis_i.following_error), $past(axis_i.cyclic_target_enabled),
        1'h0, $past(axis_i.target_reached)})
        else $error("cyclic position bits wrong");
    cst_zero_a: assert property (mode_i == 8'h0A |=> !status_bits_o[13]
        && !status_bits_o[10])
        else $error("cyclic torque bits not zero");
    pt_zero_a: assert property (mode_i == 8'h04 |=>
        status_bits_o[13:12] == 2'h0)
        else $error("profile torque reserved bits set");
    pv_speed_a: assert property (mode_i == 8'h03 |=> status_bits_o[13:12]
        == {1'h0, $past(axis_i.speed_zero)})
        else $error("profile velocity bit 12 wrong");
    home_err_a: assert property (mode_i == 8'h06 && axis_i.homing_error
        |=> {status_bits_o[13:12], status_bits_o[10]}
        == {2'h2, $past(axis_i.speed_zero)})
        else $error("homing error code wrong");
    torque_stop_a: assert property ($rose(quick_stop_i) && !stop_o.power_off
        && stop_o.decel_src == qsd_pkg::QSD_DEC_NONE
        && mode_i inside {8'h04, 8'h0A} |=> stop_o.power_off
        && stop_o.enter_sod)
        else $error("torque mode quick stop not immediate");
    decel_end_a: assert property (stop_o.decel_src != qsd_pkg::QSD_DEC_NONE
        && axis_i.axis_stopped |=> stop_o.power_off && stop_o.enter_sod
        && stop_o.decel_src == qsd_pkg::QSD_DEC_NONE)
        else $error("stop after deceleration missing");
    sod_pulse_a: assert property (stop_o.enter_sod |=> !stop_o.enter_sod)
        else $error("switch on disabled strobe too long");
endmodule

bind qsd_top qsd_chk i_qsd_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .mode_i(mode_i), .axis_i(axis_i),
    .quick_stop_i(quick_stop_i), .status_bits_o(status_bits_o),
    .stop_o(stop_o), .irq_o(irq_o)
);

/* verif/qsd_net_master.sv */
// wishbone master model standing in for the network controller
// assumes its task is entered just after a rising edge of clk_i
`timescale 1ns/1ps
module qsd_net_master (
    // clock
    input  wire logic        clk_i,
    // wishbone master side
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic      [31:0] adr_o,
    output logic      [3:0]  sel_o,
    output logic      [31:0] dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    // bus idle from time zero
    initial begin
        cyc_o = 1'h0;
        stb_o = 1'h0;
        we_o  = 1'h0;
        adr_o = 32'h0;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // one classic cycle; no latency assumed, the bench watchdog cuts hangs
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        cyc_o <= 1'h1;
        stb_o <= 1'h1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= 4'hF;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'h1);
        q = dat_i;
        cyc_o <= 1'h0;
        stb_o <= 1'h0;
        we_o  <= 1'h0;
        dat_o <= ~d; // released data no longer valid
        @(posedge clk_i);
    endtask
endmodule

/* verif/qsd_top_test.sv */
// testbench for the status mode bits and quick stop block
// assumes the checker is bound by its own file
`timescale 1ns/1ps
module qsd_top_test;
    logic               clk_i, rst_i, cyc, stb, we, ack, qs, irq;
    logic [31:0]        adr, wdat, rdat, q;
    logic [3:0]         sel;
    logic [7:0]         mode;
    logic [15:0]        st;
    qsd_pkg::qsd_axis_t axis;
    qsd_pkg::qsd_stop_t stop;
    int                 bad_count, total_checks;
    // status table: mode, axis levels (halt first), bits 13 12 10
    logic [7:0]  tm [18] = '{8'h01, 8'h01, 8'h01, 8'h06, 8'h06, 8'h06,
        8'h06, 8'h06, 8'h06, 8'h09, 8'h0A, 8'h07, 8'h07, 8'h03, 8'h03,
        8'h04, 8'h04, 8'h08};
    logic [10:0] ta [18] = '{11'h200, 11'h6C0, 11'h500, 11'h020, 11'h000,
        11'h010, 11'h110, 11'h008, 11'h00A, 11'h244, 11'h244, 11'h241,
        11'h600, 11'h242, 11'h500, 11'h2C6, 11'h600, 11'h244};
    logic [2:0]  te [18] = '{3'h1, 3'h6, 3'h1, 3'h0, 3'h1, 3'h2, 3'h3,
        3'h4, 3'h5, 3'h3, 3'h2, 3'h3, 3'h0, 3'h3, 3'h1, 3'h1, 3'h0, 3'h7};
    // quick stop table: mode, option code, expected deceleration source
    logic [7:0]  qm [7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h04, 8'h0A};
    logic [2:0]  qc [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h3, 3'h2};
    logic [1:0]  qd [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h0, 2'h0};

    qsd_top i_qsd_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .mode_i(mode), .axis_i(axis),
        .quick_stop_i(qs), .status_bits_o(st), .stop_o(stop), .irq_o(irq));
    qsd_net_master i_qsd_net_master (.clk_i(clk_i), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat),
        .dat_i(rdat), .ack_i(ack));

    // 250 MHz clock
    initial begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input string n, input logic [31:0] seen,
                       input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic rd(input logic [15:0] idx, output logic [31:0] d);
        i_qsd_net_master.xfer(1'h0, {14'h0, idx, 2'h0}, 32'h0, d);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] unused;
        i_qsd_net_master.xfer(1'h1, {14'h0, idx, 2'h0}, d, unused);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog far beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        summarize();
    end

    // main sequence
    initial begin
        rst_i = 1'h1;
        mode = 8'h01;
        axis = '0;
        qs = 1'h0;
        bad_count = 0;
        total_checks = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        rd(qsd_pkg::QSD_IDX_QS_OPTION, q);
        chk("option reset", q, 32'h2);
        rd(qsd_pkg::QSD_IDX_IRQ_MASK, q);
        chk("mask reset", q, 32'h0);
        i_qsd_net_master.xfer(1'h0, 32'h100, 32'h0, q);
        chk("unmapped", q, 32'h0);
        $display("test reset done");
        for (int v = 0; v < 5; v++) begin
            wr(qsd_pkg::QSD_IDX_QS_OPTION, 32'(v));
            rd(qsd_pkg::QSD_IDX_QS_OPTION, q);
            chk("option", q, 32'(v));
        end
        wr(qsd_pkg::QSD_IDX_QS_OPTION, 32'h5);
        wr(qsd_pkg::QSD_IDX_QS_OPTION, 32'hFFFF);
        rd(qsd_pkg::QSD_IDX_QS_OPTION, q);
        chk("option range", q, 32'h4);
        $display("test option done");
        for (int i = 0; i < 18; i++) begin
            @(posedge clk_i);
            mode <= tm[i];
            axis <= ta[i];
            @(posedge clk_i);
            #1;
            chk("status bits", st, {2'h0, te[i][2:1], 1'h0, te[i][0], 10'h0});
        end
        @(posedge clk_i);
        rd(qsd_pkg::QSD_IDX_STATUS, q);
        chk("status reg", q, 32'h3400);
        axis <= '0;
        $display("test status done");
        for (int i = 0; i < 7; i++) begin
            wr(qsd_pkg::QSD_IDX_QS_OPTION, 32'(qc[i]));
            mode <= qm[i];
            qs <= 1'h1;
            @(posedge clk_i);
            #1;
            chk("power off", stop.power_off, qd[i] == 2'h0);
            chk("decel", stop.decel_src, qd[i]);
            if (qd[i] != 2'h0) begin
                @(posedge clk_i);
                axis <= 11'h100;
                @(posedge clk_i);
                #1;
                chk("stop done", {stop.power_off, stop.decel_src}, 3'h4);
            end
            chk("enter sod", stop.enter_sod, 1'h1);
            @(posedge clk_i);
            qs <= 1'h0;
            axis <= '0;
            mode <= 8'h01;
            repeat (3) @(posedge clk_i);
            #1;
            chk("released", stop.power_off, 1'h0);
            @(posedge clk_i);
        end
        $display("test quick stop done");
        chk("irq masked", irq, 1'h0);
        wr(qsd_pkg::QSD_IDX_IRQ_MASK, 32'h1F);
        #1;
        chk("irq on", irq, 1'h1);
        @(posedge clk_i);
        rd(qsd_pkg::QSD_IDX_IRQ_STATUS, q);
        chk("irq status", q, 32'h1F);
        #1;
        chk("irq cleared", irq, 1'h0);
        @(posedge clk_i);
        rd(qsd_pkg::QSD_IDX_IRQ_STATUS, q);
        chk("irq read clear", q, 32'h0);
        wr(qsd_pkg::QSD_IDX_IRQ_MASK, 32'h10);
        wr(qsd_pkg::QSD_IDX_QS_OPTION, 32'h9);
        #1;
        chk("irq reject", irq, 1'h1);
        @(posedge clk_i);
        rd(qsd_pkg::QSD_IDX_IRQ_STATUS, q);
        chk("reject flag", q, 32'h10);
        $display("test interrupt done");
        summarize();
    end
endmodule
